// >>> fan_duty_control_bench.sv
// Self-checking bench for the fan duty control block
`timescale 1ns/100ps
module fan_duty_control_bench;
    reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ext_n = 1'b1;
    reg  [7:0]  addr = 8'h00, wdat = 8'h00, rtemp = 8'h28, rlim = 8'h50, ltemp = 8'h28;
    reg  [7:0]  auto_r = 8'h60, auto_l = 8'h70, d;
    reg  [15:0] target = 16'h0300; // target reachable by the fan
    wire [7:0]  rdat, duty;
    wire [15:0] tdata;
    wire        tvalid, meas, oe, pout, spin, alert_n;
    wire        pin = ext_n & ~(oe & ~pout);
    integer     errors = 0, checks_done = 0, cyc = 0, n;
    always #5 clk = ~clk;
    fdc_fan_duty #(.MS_CYCLES(10)) dut_u (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr),
        .REG_WR_EN(wr), .REG_WR_DATA(wdat), .REG_RD_EN(rd), .REG_RD_DATA(rdat),
        .REMOTE_TEMP(rtemp), .REMOTE_LIMIT(rlim), .LOCAL_TEMP(ltemp), .LOCAL_LIMIT(8'h50),
        .TACH_VALID(tvalid), .TACH_DATA(tdata), .TACH_TARGET(target),
        .TACH_LOW_LIMIT(16'hFFFF), .MEAS_START(meas), .AUTO_REMOTE_DUTY(auto_r),
        .AUTO_LOCAL_DUTY(auto_l), .OVT_PIN_IN(pin), .OVT_PIN_OUT(pout), .OVT_PIN_OE(oe),
        .DUTY(duty), .SPINUP_ACTIVE(spin), .ALERT_N(alert_n));
    fdc_fan_model fan_u (.clk(clk), .rst(rst), .meas_start(meas), .duty(duty),
        .tach_valid(tvalid), .tach_data(tdata));
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] v);
        begin
            @(negedge clk);
            addr = a;
            wdat = v;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
            @(negedge clk);
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(negedge clk);
            addr = a;
            rd = 1'b1;
            @(negedge clk);
            rd = 1'b0;
            @(negedge clk);
            d = rdat;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            report_and_stop;
        end
    end
    task t_spin;
        begin
            n = 0;
            while (spin !== 1'b1 && n < 20) begin @(negedge clk); n = n + 1; end
            n = 0;
            while (spin === 1'b1) begin @(negedge clk); n = n + 1; end
            chk("spin_len", {7'h0, n > 19980 && n < 20020}, 8'h01);
            repeat (3) @(negedge clk);
            chk("auto_rem", duty, auto_r);
            rd_reg(8'h02);
            chk("slow_set", d[1], 1'b1);
            rd_reg(8'h02);
            chk("slow_clr", d[1], 1'b0);
            rd_reg(8'h20);
            chk("fan_char", d, 8'h05);
        end
    endtask
    task t_modes;
        begin
            wr_reg(8'h00, 8'h60);
            chk("auto_max", duty, auto_l);
            wr_reg(8'h00, 8'h00);
            wr_reg(8'h22, 8'h11);
            chk("sw_low", duty, 8'h00);
            wr_reg(8'h22, 8'h12);
            chk("sw_edge", duty, 8'h12);
            wr_reg(8'h01, 8'h06);
            wr_reg(8'h22, 8'h11);
            chk("sw_tmode", duty, 8'h11);
            wr_reg(8'h01, 8'h04);
            ext_n = 1'b0;
            repeat (8) @(negedge clk);
            chk("ext_full", duty, 8'hFF);
            rd_reg(8'h03);
            chk("ext_bit", d[3], 1'b1);
            ext_n = 1'b1;
            repeat (8) @(negedge clk);
        end
    endtask
    task t_ovt;
        begin
            wr_reg(8'h00, 8'h08);
            rtemp = 8'h51;
            repeat (4) @(negedge clk);
            chk("pin", oe, 1'b1);
            chk("alert", alert_n, 1'b0);
            chk("no_force", duty, 8'h00);
            rd_reg(8'h02);
            chk("rem_flag", d[4], 1'b1);
            chk("alert_rel", alert_n, 1'b1);
            rtemp = 8'h4C;
            repeat (4) @(negedge clk);
            chk("pin_hold", oe, 1'b1);
            rtemp = 8'h51;
            repeat (4) @(negedge clk);
            chk("no_rearm", alert_n, 1'b1);
            wr_reg(8'h04, 8'h08);
            chk("fs_full", duty, 8'hFF);
            rtemp = 8'h4B;
            repeat (4) @(negedge clk);
            chk("pin_off", oe, 1'b0);
            chk("fs_end", duty, 8'h00);
        end
    endtask
    task t_reg;
        begin
            wr_reg(8'h23, 8'h60);
            wr_reg(8'h04, 8'h20);
            wr_reg(8'h00, 8'h20);
            @(posedge tvalid);
            repeat (2) begin
                @(negedge clk);
                d = duty;
                repeat (3) @(negedge clk);
                chk("reg_step", duty, d + 8'h04);
                n = 4;
                while (tvalid !== 1'b1) begin @(negedge clk); n = n + 1; end
                chk("period", {7'h0, n > 2490 && n < 2510}, 8'h01);
            end
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_spin;
        t_modes;
        t_ovt;
        t_reg;
        report_and_stop;
    end
endmodule // fan_duty_control_bench

// >>> fdc_defines.vh
// Constants shared by the fan duty control block
`ifndef FDC_DEFINES_VH
`define FDC_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FDC_ADDR_CFG1        8'h00
`define FDC_ADDR_CFG2        8'h01
`define FDC_ADDR_STAT1       8'h02
`define FDC_ADDR_STAT2       8'h03
`define FDC_ADDR_CFG4        8'h04
`define FDC_ADDR_FAN_CHAR    8'h20
`define FDC_ADDR_DUTY        8'h22
`define FDC_ADDR_RAMP        8'h23

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FDC_CFG1_MODE_HI     6
`define FDC_CFG1_MODE_LO     5
`define FDC_CFG1_IRQ_EN      3
`define FDC_CFG2_TACH_EN     2
`define FDC_CFG2_TACH_MODE   1
`define FDC_CFG4_TACH_FAST   5
`define FDC_CFG4_FS_EN       3
`define FDC_STAT1_FAN_SLOW   1
`define FDC_STAT1_OVL_REM    4
`define FDC_STAT2_EXT_REQ    3
`define FDC_STAT2_OVL_LOC    4
`define FDC_CHAR_STIME_HI    2
`define FDC_CHAR_STIME_LO    0
`define FDC_CHAR_SPIN_DIS    5
`define FDC_RAMP_STEP_HI     6
`define FDC_RAMP_STEP_LO     5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FDC_RST_CFG1         8'h40
`define FDC_RST_CFG2         8'h04
`define FDC_RST_CFG4         8'h00
`define FDC_RST_FAN_CHAR     8'h05
`define FDC_RST_DUTY         8'h00
`define FDC_RST_RAMP         8'h00

// ----------------------------------------------------------------------------
// Modes
// ----------------------------------------------------------------------------
`define FDC_MODE_SW_DUTY     2'h0
`define FDC_MODE_SW_SPEED    2'h1
`define FDC_MODE_AUTO_REM    2'h2
`define FDC_MODE_AUTO_MAX    2'h3

// ----------------------------------------------------------------------------
// Duty levels (255 = 100%) and thresholds
// ----------------------------------------------------------------------------
`define FDC_DUTY_FULL        8'hFF
`define FDC_DUTY_ZERO        8'h00
`define FDC_DUTY_SPIN_BASE   8'h55
`define FDC_DUTY_SPIN_SPAN   8'hAA
`define FDC_DUTY_SW_MIN      8'h12
`define FDC_DUTY_REG_FLOOR   8'h4D
`define FDC_TEMP_HYST        8'h05
`define FDC_TACH_TOL         16'h000A

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FDC_CLK_PERIOD_NS    10
`define FDC_MS_NS            1000000
`define FDC_MS_CYCLES        (`FDC_MS_NS / `FDC_CLK_PERIOD_NS)
`define FDC_PERIOD_STD_MS    14'h03E8
`define FDC_PERIOD_FAST_MS   14'h00FA

`endif

// >>> fdc_fan_duty.v
// Fan duty control: over-temperature pin, spin-up and normal duty modes
//
// How it works
// - Pin low above limit until 5C below
// - Over-limit sets flag; alert needs enable
// - Pin low while either flag set
// - Status read clears flags, releases alert
// - Cleared flag re-arms only after hysteresis
// - Enable bit plus pin low forces full
// - External pull low forces full, sets bit
// - Spin-up ramps then holds full duty
// - After spin-up: regulator restarts at one third, measure
// - Three-bit spin-up time selection table
// - Disable bit skips fan-slow spin-ups only
// - Reset clears disable, always spins up
// - No slow detection during spin-up
// - Slow flag stays set after spin-up
// - Mode 00 software duty, 01 regulator
// - Mode 10 remote auto, 11 max
// - Software duty applies immediately after write
// - Software duty below 7% gives zero when tach enabled, mode bit clear
// - Regulator runs only with tach enabled
// - Regulator period one second or 250ms
// - Step per period, stop within tolerance
// - Regulator duty floor thirty percent, tach mode bit clear
// - Larger tach is slower; sets slow
`timescale 1ns/100ps
`include "fdc_defines.vh"

module fdc_fan_duty #(
    parameter MS_CYCLES = `FDC_MS_CYCLES
) (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        RST,
    // Register port
    input  wire [7:0]  REG_ADDR,
    input  wire        REG_WR_EN,
    input  wire [7:0]  REG_WR_DATA,
    input  wire        REG_RD_EN,
    output reg  [7:0]  REG_RD_DATA,
    // Temperatures and limits
    input  wire [7:0]  REMOTE_TEMP,
    input  wire [7:0]  REMOTE_LIMIT,
    input  wire [7:0]  LOCAL_TEMP,
    input  wire [7:0]  LOCAL_LIMIT,
    // Tach measurement
    input  wire        TACH_VALID,
    input  wire [15:0] TACH_DATA,
    input  wire [15:0] TACH_TARGET,
    input  wire [15:0] TACH_LOW_LIMIT,
    output reg         MEAS_START,
    // Automatic loop demands
    input  wire [7:0]  AUTO_REMOTE_DUTY,
    input  wire [7:0]  AUTO_LOCAL_DUTY,
    // Over-temperature pin
    input  wire        OVT_PIN_IN,
    output wire        OVT_PIN_OUT,
    output reg         OVT_PIN_OE,
    // Fan outputs
    output reg  [7:0]  DUTY,
    output reg         SPINUP_ACTIVE,
    output reg         ALERT_N
);

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    reg  [7:0]  cfg1_reg;
    reg  [7:0]  cfg2_reg;
    reg  [7:0]  fan_config_four_reg;
    reg  [7:0]  fan_characteristics_reg;
    reg  [7:0]  duty_setting_reg;
    reg  [7:0]  duty_ramp_config_reg;

    wire [1:0] control_mode_sel    = cfg1_reg[`FDC_CFG1_MODE_HI:`FDC_CFG1_MODE_LO];
    wire       overlimit_irq_enable = cfg1_reg[`FDC_CFG1_IRQ_EN];
    wire       tach_en             = cfg2_reg[`FDC_CFG2_TACH_EN];
    wire       tach_mode           = cfg2_reg[`FDC_CFG2_TACH_MODE];
    wire       tach_fast           = fan_config_four_reg[`FDC_CFG4_TACH_FAST];
    wire       full_speed_en       = fan_config_four_reg[`FDC_CFG4_FS_EN];
    wire [2:0] spinup_time_sel     =
        fan_characteristics_reg[`FDC_CHAR_STIME_HI:`FDC_CHAR_STIME_LO];
    wire       spinup_disable      = fan_characteristics_reg[`FDC_CHAR_SPIN_DIS];
    wire [1:0] adjust_step_sel     =
        duty_ramp_config_reg[`FDC_RAMP_STEP_HI:`FDC_RAMP_STEP_LO];

    wire rd_stat1 = REG_RD_EN && (REG_ADDR == `FDC_ADDR_STAT1);
    wire rd_stat2 = REG_RD_EN && (REG_ADDR == `FDC_ADDR_STAT2);
    wire ovl_clear = rd_stat1 || rd_stat2;

    always @(posedge REF_CLK) begin
        if (RST) begin
            cfg1_reg                <= `FDC_RST_CFG1;
            cfg2_reg                <= `FDC_RST_CFG2;
            fan_config_four_reg     <= `FDC_RST_CFG4;
            fan_characteristics_reg <= `FDC_RST_FAN_CHAR;
            duty_setting_reg        <= `FDC_RST_DUTY;
            duty_ramp_config_reg    <= `FDC_RST_RAMP;
        end else if (REG_WR_EN) begin
            case (REG_ADDR)
                `FDC_ADDR_CFG1:     cfg1_reg                <= REG_WR_DATA;
                `FDC_ADDR_CFG2:     cfg2_reg                <= REG_WR_DATA;
                `FDC_ADDR_CFG4:     fan_config_four_reg     <= REG_WR_DATA;
                `FDC_ADDR_FAN_CHAR: fan_characteristics_reg <= REG_WR_DATA;
                `FDC_ADDR_DUTY:     duty_setting_reg        <= REG_WR_DATA;
                `FDC_ADDR_RAMP:     duty_ramp_config_reg    <= REG_WR_DATA;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Over-limit tracking per channel
    // ------------------------------------------------------------------------
    // Limits below the hysteresis clamp at zero so the release is reachable
    function below_hyst;
        input [7:0] temp;
        input [7:0] limit;
        begin
            if (limit < `FDC_TEMP_HYST)
                below_hyst = (temp == 8'h00);
            else
                below_hyst = (temp <= limit - `FDC_TEMP_HYST);
        end
    endfunction

    wire rem_over = REMOTE_TEMP > REMOTE_LIMIT;
    wire loc_over = LOCAL_TEMP > LOCAL_LIMIT;
    wire rem_rel  = below_hyst(REMOTE_TEMP, REMOTE_LIMIT);
    wire loc_rel  = below_hyst(LOCAL_TEMP, LOCAL_LIMIT);

    reg rem_hold_reg, loc_hold_reg;
    reg rem_flag_reg, loc_flag_reg;
    reg rem_armed_reg, loc_armed_reg;

    always @(posedge REF_CLK) begin
        if (RST) begin
            rem_hold_reg  <= 1'b0;
            loc_hold_reg  <= 1'b0;
            rem_flag_reg  <= 1'b0;
            loc_flag_reg  <= 1'b0;
            rem_armed_reg <= 1'b1;
            loc_armed_reg <= 1'b1;
        end else begin
            if (rem_over)
                rem_hold_reg <= 1'b1;
            else if (rem_rel)
                rem_hold_reg <= 1'b0;
            if (loc_over)
                loc_hold_reg <= 1'b1;
            else if (loc_rel)
                loc_hold_reg <= 1'b0;
            // set flag on excursion; set beats clear
            if (rem_over && rem_armed_reg)
                rem_flag_reg <= 1'b1;
            else if (ovl_clear)
                rem_flag_reg <= 1'b0;
            if (loc_over && loc_armed_reg)
                loc_flag_reg <= 1'b1;
            else if (ovl_clear)
                loc_flag_reg <= 1'b0;
            // one flag per excursion, re-arm on hysteresis
            if (rem_over && rem_armed_reg)
                rem_armed_reg <= 1'b0;
            else if (rem_rel)
                rem_armed_reg <= 1'b1;
            if (loc_over && loc_armed_reg)
                loc_armed_reg <= 1'b0;
            else if (loc_rel)
                loc_armed_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Over-temperature pin
    // ------------------------------------------------------------------------
    // Open drain: only ever drives low
    assign OVT_PIN_OUT = 1'b0;

    reg ovt_s1_reg, ovt_s2_reg, ovt_s3_reg, ovt_level_reg;
    reg [3:0] oe_hist_reg;
    always @(posedge REF_CLK) begin
        if (RST) begin
            oe_hist_reg   <= 4'h0;
            ovt_s1_reg    <= 1'b1;
            ovt_s2_reg    <= 1'b1;
            ovt_s3_reg    <= 1'b1;
            ovt_level_reg <= 1'b1;
        end else begin
            oe_hist_reg <= {oe_hist_reg[2:0], OVT_PIN_OE};
            ovt_s1_reg <= OVT_PIN_IN;
            ovt_s2_reg <= ovt_s1_reg;
            ovt_s3_reg <= ovt_s2_reg;
            if (ovt_s2_reg == ovt_s3_reg)
                ovt_level_reg <= ovt_s3_reg;
        end
    end

    // flags drive the pin regardless of enable
    wire ovt_drive_next = rem_hold_reg || loc_hold_reg || rem_flag_reg || loc_flag_reg;
    // low pin not of our making is a request
    // Own release still looks low through the synchroniser for four cycles
    wire ext_req = !ovt_level_reg && !OVT_PIN_OE && (oe_hist_reg == 4'h0);

    always @(posedge REF_CLK) begin
        if (RST) begin
            OVT_PIN_OE <= 1'b0;
            ALERT_N    <= 1'b1;
        end else begin
            OVT_PIN_OE <= ovt_drive_next;
            ALERT_N    <= !(overlimit_irq_enable && (rem_flag_reg || loc_flag_reg));
        end
    end

    // ------------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------------
    // Millisecond prescaler keeps the long spans in narrow counters
    reg  [31:0] ms_cnt_reg;
    reg         ms_tick_reg;
    reg  [13:0] period_cnt_reg;
    wire        spin_done;
    wire        spin_active;
    wire [7:0]  spin_duty;

    wire [13:0] period_ms = tach_fast ? `FDC_PERIOD_FAST_MS : `FDC_PERIOD_STD_MS;

    always @(posedge REF_CLK) begin
        if (RST) begin
            ms_cnt_reg     <= 32'h00000000;
            ms_tick_reg    <= 1'b0;
            period_cnt_reg <= 14'h0000;
            MEAS_START     <= 1'b0;
        end else begin
            ms_tick_reg <= 1'b0;
            MEAS_START  <= 1'b0;
            if (ms_cnt_reg >= MS_CYCLES - 1) begin
                ms_cnt_reg  <= 32'h00000000;
                ms_tick_reg <= 1'b1;
            end else begin
                ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
            end
            if (spin_done) begin
                period_cnt_reg <= 14'h0000;
                MEAS_START     <= 1'b1;
            end else if (ms_tick_reg) begin
                if (period_cnt_reg + 14'h0001 >= period_ms) begin
                    period_cnt_reg <= 14'h0000;
                    MEAS_START     <= tach_en;
                end else begin
                    period_cnt_reg <= period_cnt_reg + 14'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Spin-up and fan-slow
    // ------------------------------------------------------------------------
    reg  fan_slow_reg;
    reg  spin_pending_reg;
    wire tach_slow = TACH_DATA > TACH_LOW_LIMIT;

    always @(posedge REF_CLK) begin
        if (RST) begin
            fan_slow_reg     <= 1'b0;
            spin_pending_reg <= 1'b1;
        end else begin
            if (spin_active)
                spin_pending_reg <= 1'b0;
            else if (TACH_VALID && tach_slow && !spinup_disable)
                spin_pending_reg <= 1'b1;
            if (spin_done)
                fan_slow_reg <= 1'b1;
            else if (TACH_VALID && tach_slow && !spin_active)
                fan_slow_reg <= 1'b1;
            // cleared only by a read of status register 1
            else if (rd_stat1)
                fan_slow_reg <= 1'b0;
        end
    end

    fdc_spinup u_spinup (
        .clk        (REF_CLK),
        .rst        (RST),
        .start      (spin_pending_reg),
        .time_sel   (spinup_time_sel),
        .ms_tick    (ms_tick_reg),
        .active_reg (spin_active),
        .duty_reg   (spin_duty),
        .done_reg   (spin_done)
    );

    // ------------------------------------------------------------------------
    // Speed regulator
    // ------------------------------------------------------------------------
    reg  [7:0] reg_duty_reg;
    wire [7:0] step = {6'h00, adjust_step_sel} + 8'h01;
    wire [8:0] up_sum = {1'b0, reg_duty_reg} + {1'b0, step};

    always @(posedge REF_CLK) begin
        if (RST) begin
            reg_duty_reg <= `FDC_DUTY_SPIN_BASE;
        end else if (spin_done) begin
            reg_duty_reg <= `FDC_DUTY_SPIN_BASE;
        end else if (TACH_VALID && tach_en && !spin_active
                     && control_mode_sel == `FDC_MODE_SW_SPEED) begin
            if ({1'b0, TACH_DATA} > {1'b0, TACH_TARGET} + {1'b0, `FDC_TACH_TOL})
                reg_duty_reg <= up_sum[8] ? `FDC_DUTY_FULL : up_sum[7:0];
            else if ({1'b0, TACH_DATA} + {1'b0, `FDC_TACH_TOL} < {1'b0, TACH_TARGET})
                reg_duty_reg <= (reg_duty_reg < step) ? `FDC_DUTY_ZERO
                                                      : reg_duty_reg - step;
        end
    end

    // ------------------------------------------------------------------------
    // Duty selection
    // ------------------------------------------------------------------------
    reg [7:0] mode_duty;
    reg [7:0] duty_next;

    always @* begin
        case (control_mode_sel)
            // written value used with no ramp
            `FDC_MODE_SW_DUTY: begin
                if (tach_en && !tach_mode && duty_setting_reg < `FDC_DUTY_SW_MIN)
                    mode_duty = `FDC_DUTY_ZERO;
                else
                    mode_duty = duty_setting_reg;
            end
            `FDC_MODE_SW_SPEED: begin
                if (!tach_mode && reg_duty_reg < `FDC_DUTY_REG_FLOOR)
                    mode_duty = `FDC_DUTY_REG_FLOOR;
                else
                    mode_duty = reg_duty_reg;
            end
            // remote loop, or the faster loop
            `FDC_MODE_AUTO_REM: mode_duty = AUTO_REMOTE_DUTY;
            default: mode_duty = (AUTO_LOCAL_DUTY > AUTO_REMOTE_DUTY) ?
                                 AUTO_LOCAL_DUTY : AUTO_REMOTE_DUTY;
        endcase
        // pin override, then spin-up, then mode
        // enable bit with pin driven low
        if (ext_req || (full_speed_en && OVT_PIN_OE))
            duty_next = `FDC_DUTY_FULL;
        else if (spin_active)
            duty_next = spin_duty;
        else
            duty_next = mode_duty;
    end

    always @(posedge REF_CLK) begin
        if (RST) begin
            DUTY          <= `FDC_DUTY_ZERO;
            SPINUP_ACTIVE <= 1'b0;
        end else begin
            DUTY          <= duty_next;
            SPINUP_ACTIVE <= spin_active;
        end
    end

    // ------------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------------
    always @(posedge REF_CLK) begin
        if (RST) begin
            REG_RD_DATA <= 8'h00;
        end else if (REG_RD_EN) begin
            case (REG_ADDR)
                `FDC_ADDR_CFG1:     REG_RD_DATA <= cfg1_reg;
                `FDC_ADDR_CFG2:     REG_RD_DATA <= cfg2_reg;
                `FDC_ADDR_STAT1: begin
                    REG_RD_DATA <= 8'h00;
                    REG_RD_DATA[`FDC_STAT1_FAN_SLOW] <= fan_slow_reg;
                    REG_RD_DATA[`FDC_STAT1_OVL_REM]  <= rem_flag_reg;
                end
                `FDC_ADDR_STAT2: begin
                    REG_RD_DATA <= 8'h00;
                    REG_RD_DATA[`FDC_STAT2_EXT_REQ] <= ext_req;
                    REG_RD_DATA[`FDC_STAT2_OVL_LOC] <= loc_flag_reg;
                end
                `FDC_ADDR_CFG4:     REG_RD_DATA <= fan_config_four_reg;
                `FDC_ADDR_FAN_CHAR: REG_RD_DATA <= fan_characteristics_reg;
                `FDC_ADDR_DUTY:     REG_RD_DATA <= duty_setting_reg;
                `FDC_ADDR_RAMP:     REG_RD_DATA <= duty_ramp_config_reg;
                default:            REG_RD_DATA <= 8'h00;
            endcase
        end
    end

endmodule // fdc_fan_duty

// >>> fdc_fan_model.sv
// Fan model: answers a measurement request with a duty-dependent period
`timescale 1ns/100ps
module fdc_fan_model (
    input  wire        clk, rst, meas_start,
    input  wire [7:0]  duty,
    output reg         tach_valid,
    output reg  [15:0] tach_data
);
    reg [3:0] wait_reg;
    always @(posedge clk) begin
        // larger is slower; data toggles outside a result
        tach_data <= rst ? 16'h0000 : (wait_reg == 4'h1) ? 16'h0400 - {8'h00, duty} : ~tach_data;
        tach_valid <= !rst && wait_reg == 4'h1;
        if (rst)
            wait_reg <= 4'h0;
        else if (meas_start)
            wait_reg <= 4'h8;
        else if (wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
    end
endmodule // fdc_fan_model

// >>> fdc_monitor.sv
// Port assertions for the fan duty control block
`timescale 1ns/100ps
module fdc_monitor (
    // Clock, reset and read strobe
    input wire       REF_CLK, RST, REG_RD_EN,
    input wire [7:0] REG_ADDR,
    // Temperatures, pin and fan
    input wire [7:0] REMOTE_TEMP, REMOTE_LIMIT, LOCAL_TEMP, LOCAL_LIMIT, DUTY,
    input wire       OVT_PIN_IN, OVT_PIN_OE, MEAS_START, SPINUP_ACTIVE, ALERT_N
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire over = (REMOTE_TEMP > REMOTE_LIMIT) || (LOCAL_TEMP > LOCAL_LIMIT);
    // Nine bits so a small limit cannot wrap
    wire cool = ({1'b0, REMOTE_TEMP} + 9'h5 <= {1'b0, REMOTE_LIMIT} || REMOTE_TEMP == 8'h0)
             && ({1'b0, LOCAL_TEMP} + 9'h5 <= {1'b0, LOCAL_LIMIT} || LOCAL_TEMP == 8'h0);
    sequence ext_low; (!OVT_PIN_IN && !OVT_PIN_OE) [*6]; endsequence
    sequence spin_on; SPINUP_ACTIVE [*3]; endsequence
    sequence stat_rd; REG_RD_EN && REG_ADDR[7:1] == 7'h01 && !ALERT_N; endsequence
    ovt_set_a: assert property (over |-> ##[1:2] OVT_PIN_OE)
        else $error("pin not pulled low");
    ovt_release_a: assert property ($fell(OVT_PIN_OE) |-> $past(cool, 2))
        else $error("pin released too early");
    alert_pin_a: assert property (!ALERT_N |-> OVT_PIN_OE)
        else $error("alert without pin low");
    alert_clear_a: assert property (stat_rd |-> ##[1:2] ALERT_N)
        else $error("alert kept after read");
    ext_full_a: assert property (ext_low |-> DUTY == 8'hFF)
        else $error("external request not full");
    spin_start_a: assert property ($rose(SPINUP_ACTIVE) |-> ##[0:3] DUTY == 8'h55)
        else $error("spin-up base wrong");
    spin_floor_a: assert property (spin_on |-> DUTY >= 8'h55)
        else $error("spin-up duty low");
    spin_meas_a: assert property ($fell(SPINUP_ACTIVE) |-> $past(MEAS_START) or ##[0:3] MEAS_START)
        else $error("no measurement after spin-up");
endmodule // fdc_monitor
bind fdc_fan_duty fdc_monitor mon_u (.REF_CLK(REF_CLK), .RST(RST), .REG_RD_EN(REG_RD_EN),
    .REG_ADDR(REG_ADDR), .REMOTE_TEMP(REMOTE_TEMP), .REMOTE_LIMIT(REMOTE_LIMIT),
    .LOCAL_TEMP(LOCAL_TEMP), .LOCAL_LIMIT(LOCAL_LIMIT), .DUTY(DUTY), .OVT_PIN_IN(OVT_PIN_IN),
    .OVT_PIN_OE(OVT_PIN_OE), .MEAS_START(MEAS_START), .SPINUP_ACTIVE(SPINUP_ACTIVE),
    .ALERT_N(ALERT_N));

// >>> fdc_spinup.v
// Spin-up sequencer: timed ramp from one third to full duty
`timescale 1ns/100ps
`include "fdc_defines.vh"

module fdc_spinup (
    // Clock and reset
    input  wire       clk,
    input  wire       rst,
    // Control
    input  wire       start,
    input  wire [2:0] time_sel,
    input  wire       ms_tick,
    // Status
    output reg        active_reg,
    output reg  [7:0] duty_reg,
    output reg        done_reg
);

    // ------------------------------------------------------------------------
    // Duration table
    // ------------------------------------------------------------------------
    // spin-up duration table
    function [13:0] spin_ms;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    spin_ms = 14'h00C8;
                3'h1:    spin_ms = 14'h0190;
                3'h2:    spin_ms = 14'h0258;
                3'h3:    spin_ms = 14'h0320;
                3'h4:    spin_ms = 14'h03E8;
                3'h5:    spin_ms = 14'h07D0;
                3'h6:    spin_ms = 14'h0FA0;
                default: spin_ms = 14'h1F40;
            endcase
        end
    endfunction

    reg  [13:0] total_reg;
    reg  [13:0] elapsed_reg;
    wire [15:0] elapsed_x3 = {2'h0, elapsed_reg} * 16'h0003;
    wire [22:0] ramp_num   = {9'h000, elapsed_reg} * 23'h0001FE;
    wire [22:0] ramp_q     = ramp_num / {9'h000, total_reg};
    wire [7:0]  ramp_duty  = `FDC_DUTY_SPIN_BASE + ramp_q[7:0];

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always @(posedge clk) begin
        done_reg <= 1'b0;
        if (rst) begin
            active_reg  <= 1'b0;
            duty_reg    <= `FDC_DUTY_SPIN_BASE;
            total_reg   <= 14'h0001;
            elapsed_reg <= 14'h0000;
        end else if (start && !active_reg) begin
            active_reg  <= 1'b1;
            total_reg   <= spin_ms(time_sel);
            elapsed_reg <= 14'h0000;
            duty_reg    <= `FDC_DUTY_SPIN_BASE;
        end else if (active_reg) begin
            if (elapsed_x3 >= {2'h0, total_reg})
                duty_reg <= `FDC_DUTY_FULL;
            else
                duty_reg <= ramp_duty;
            if (ms_tick) begin
                if (elapsed_reg + 14'h0001 >= total_reg) begin
                    active_reg <= 1'b0;
                    done_reg   <= 1'b1;
                end
                elapsed_reg <= elapsed_reg + 14'h0001;
            end
        end
    end

endmodule // fdc_spinup
